// file: bench/mesh_header_gen_net_iface_tb_top.sv
// Self-checking bench for the mesh header generator and network interface
`timescale 1ns/1ps
`include "mhg_consts.vh"
module mesh_header_gen_net_iface_tb_top;
  logic        ref_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [5:0]  avs_address_in = 6'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic        cache_miss_in = 1'b0;
  logic        gn_rx_valid_in = 1'b0;
  logic [31:0] gn_rx_data_in = 32'h0;
  logic        slow_r = 1'b0;
  logic [31:0] rd;
  wire  [31:0] avs_readdata_out, mn_tx_data_out, gn_tx_data_out, mn_rx_data_in;
  wire         avs_waitrequest_out, mn_tx_valid_out, mn_tx_ready_in, gn_tx_valid_out;
  wire         gn_tx_ready_in, mn_rx_valid_in, mn_rx_ready_out, gn_rx_ready_out;
  wire         ext_irq_out, wd_irq_out;
  int          err_total = 0;
  int          checked = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  mhg_net_iface i_mhg_net_iface
  (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .cache_miss_in(cache_miss_in), .mn_tx_valid_out(mn_tx_valid_out),
    .mn_tx_data_out(mn_tx_data_out), .mn_tx_ready_in(mn_tx_ready_in),
    .gn_tx_valid_out(gn_tx_valid_out), .gn_tx_data_out(gn_tx_data_out),
    .gn_tx_ready_in(gn_tx_ready_in), .mn_rx_valid_in(mn_rx_valid_in),
    .mn_rx_data_in(mn_rx_data_in), .mn_rx_ready_out(mn_rx_ready_out),
    .gn_rx_valid_in(gn_rx_valid_in), .gn_rx_data_in(gn_rx_data_in),
    .gn_rx_ready_out(gn_rx_ready_out), .ext_irq_out(ext_irq_out), .wd_irq_out(wd_irq_out)
  );
  mhg_edge_model i_mhg_edge_model
  (
    .clk_in(ref_clk_in), .slow_in(slow_r), .mn_valid_in(mn_tx_valid_out),
    .mn_data_in(mn_tx_data_out), .mn_ready_out(mn_tx_ready_in), .gn_valid_in(gn_tx_valid_out),
    .gn_data_in(gn_tx_data_out), .gn_ready_out(gn_tx_ready_in), .rx_valid_out(mn_rx_valid_in),
    .rx_data_out(mn_rx_data_in), .rx_ready_in(mn_rx_ready_out)
  );
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low, then released
  task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    avs_address_in <= {idx, 2'h0};
    avs_writedata_in <= wd;
    avs_write_in <= wr_en;
    avs_read_in <= !wr_en;
    for (n = 0; n < 300; n++)
    begin
      @(posedge ref_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
    if (n == 300)
    begin
      err_total++;
      summarize();
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // Reset value, unmapped word, then a tile header
  task automatic t_tile();
    rdc(`MHG_A_WD_LIM, 32'h0000ffff);
    rdc(4'hf, 32'h0);
    wr(`MHG_A_POS, 32'h65);
    wr(`MHG_A_VIRT, 32'h221863);
    wr(`MHG_A_IMM, 32'h0400);
    wr(`MHG_A_TILE_OP, 32'hffffffee);
    rdc(`MHG_A_RESULT, {12'h040, 5'd3, 5'd5, 5'd7, 5'd8});
  endtask
  task automatic mem_case(input logic ext, input logic [31:0] a, input logic [31:0] exp);
    wr(`MHG_A_EDGE, {31'h2927, ext});
    wr(`MHG_A_MEM_OP, a);
    rdc(`MHG_A_RESULT, exp);
  endtask
  // All four edges of the chip from the memory header
  task automatic t_mem();
    wr(`MHG_A_IMM, 32'h1ff0);
    mem_case(1'b0, 32'h7c000000, {3'h4, 9'h1ff, 5'd3, 5'd5, 5'd15, 5'd7});
    mem_case(1'b1, 32'h7c000000, {3'h2, 9'h1ff, 5'd3, 5'd5, 5'd15, 5'd0});
    mem_case(1'b1, 32'hbc000000, {3'h3, 9'h1ff, 5'd3, 5'd5, 5'd9, 5'd7});
    mem_case(1'b1, 32'hfc000000, {3'h5, 9'h1ff, 5'd3, 5'd5, 5'd0, 5'd7});
  endtask
  // Back-to-back sends into a stalling router; a partial message still leaves
  task automatic t_tx();
    int n;
    slow_r <= 1'b1;
    wr(`MHG_A_MEM_TX, 32'ha1);
    wr(`MHG_A_MEM_TX, 32'ha2);
    wr(`MHG_A_GEN_TX, 32'h03000000);
    wr(`MHG_A_GEN_TX, 32'hb2);
    for (n = 0; n < 40 && i_mhg_edge_model.gn_q.size() < 2; n++)
      @(posedge ref_clk_in);
    if (n == 40)
    begin
      err_total++;
      summarize();
    end
    slow_r <= 1'b0;
    chk(i_mhg_edge_model.mn_q[0], 32'ha1);
    chk(i_mhg_edge_model.mn_q[1], 32'ha2);
    chk(i_mhg_edge_model.gn_q[0], 32'h03000000);
    chk(i_mhg_edge_model.gn_q[1], 32'hb2);
  endtask
  // Payload delivery, interrupt removal, store acks, masking during a miss
  task automatic t_rx();
    fork
      begin
        i_mhg_edge_model.send(32'h02000000);
        i_mhg_edge_model.send(32'hc1);
        i_mhg_edge_model.send(32'hc2);
        i_mhg_edge_model.send(32'h00f00000);
        i_mhg_edge_model.send(32'h00e00000);
        i_mhg_edge_model.send(32'h00e00400);
      end
      begin
        rdc(`MHG_A_MEM_RX, 32'hc1);
        rdc(`MHG_A_MEM_RX, 32'hc2);
      end
    join
    rdc(`MHG_A_ST_CNT, 32'h0101);
    chk(i_mhg_edge_model.stalls, 32'h0);
    chk({31'h0, ext_irq_out}, 32'h1);
    cache_miss_in <= 1'b1;
    fork
      rdc(`MHG_A_STATUS, 32'h1);
      begin
        repeat (5) @(posedge ref_clk_in);
        chk({31'h0, ext_irq_out}, 32'h0);
        cache_miss_in <= 1'b0;
      end
    join
    wr(`MHG_A_STATUS, 32'h1);
    rdc(`MHG_A_STATUS, 32'h0);
  endtask
  // Unread general net word trips a small watchdog limit
  task automatic t_wd();
    wr(`MHG_A_WD_LIM, 32'h4);
    gn_rx_data_in <= 32'hd1;
    gn_rx_valid_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    chk({31'h0, wd_irq_out}, 32'h1);
    rdc(`MHG_A_WD_LIM, 32'h00040004);
    rdc(`MHG_A_GEN_RX, 32'hd1);
    gn_rx_valid_in <= 1'b0;
    gn_rx_data_in <= 32'hffffff2e;
    @(posedge ref_clk_in);
    rdc(`MHG_A_WD_LIM, 32'h4);
    wr(`MHG_A_STATUS, 32'h6);
    rdc(`MHG_A_STATUS, 32'h4);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    t_tile();
    t_mem();
    t_tx();
    t_rx();
    t_wd();
    summarize();
  end
endmodule // mesh_header_gen_net_iface_tb_top

// file: bench/mhg_edge_model.sv
// Router and edge device model facing the tile network ports
`timescale 1ns/1ps
module mhg_edge_model
(
  input  wire        clk_in,
  input  wire        slow_in,
  input  wire        mn_valid_in,
  input  wire [31:0] mn_data_in,
  output reg         mn_ready_out,
  input  wire        gn_valid_in,
  input  wire [31:0] gn_data_in,
  output reg         gn_ready_out,
  output reg         rx_valid_out,
  output reg  [31:0] rx_data_out,
  input  wire        rx_ready_in
);
  logic [31:0] mn_q[$];
  logic [31:0] gn_q[$];
  logic [2:0]  tick_r = 3'h0;
  int          stalls = 0;
  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 32'h0;
  end
  // Sink words; slow mode accepts one cycle in eight to back up the tile
  always @(posedge clk_in)
  begin
    if (mn_valid_in && mn_ready_out) mn_q.push_back(mn_data_in);
    if (gn_valid_in && gn_ready_out) gn_q.push_back(gn_data_in);
    tick_r <= tick_r + 3'h1;
    mn_ready_out <= !slow_in || tick_r == 3'h3;
    gn_ready_out <= !slow_in || tick_r == 3'h6;
  end
  // One word held until taken; a released bus shows the inverse word
  task automatic send(input logic [31:0] w);
    int n;
    rx_valid_out <= 1'b1;
    rx_data_out <= w;
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk_in);
      if (rx_ready_in === 1'b1) break;
    end
    if (n == 300) stalls++;
    rx_valid_out <= 1'b0;
    rx_data_out <= ~w;
    @(posedge clk_in);
  endtask
endmodule // mhg_edge_model

// file: bench/mhg_net_iface_asserts.sv
// Port checker for the mesh header generator and network interface
`timescale 1ns/1ps
`include "mhg_consts.vh"
module mhg_net_iface_asserts
(
  input wire        ref_clk_in,
  input wire        arst_n_in,
  input wire [5:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire        avs_waitrequest_out,
  input wire        cache_miss_in,
  input wire        mn_tx_valid_out,
  input wire [31:0] mn_tx_data_out,
  input wire        mn_tx_ready_in,
  input wire        gn_tx_valid_out,
  input wire [31:0] gn_tx_data_out,
  input wire        gn_tx_ready_in,
  input wire        gn_rx_valid_in,
  input wire        gn_rx_ready_out,
  input wire        ext_irq_out,
  input wire        wd_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Request and take conditions seen from the pins
  wire       req_w = avs_read_in || avs_write_in;
  wire [3:0] idx_w = avs_address_in[5:2];
  wire       mn_take_w = avs_write_in && avs_waitrequest_out && !cache_miss_in
                         && idx_w == `MHG_A_MEM_TX && (!mn_tx_valid_out || mn_tx_ready_in);
  wire       gn_take_w = avs_write_in && avs_waitrequest_out && !cache_miss_in
                         && idx_w == `MHG_A_GEN_TX && (!gn_tx_valid_out || gn_tx_ready_in);
  a_miss_irq_off: assert property (cache_miss_in |-> !ext_irq_out && !wd_irq_out)
    else $error("interrupt visible during cache miss");
  a_miss_no_take: assert property (cache_miss_in && req_w |=> avs_waitrequest_out || !req_w)
    else $error("bus request taken during cache miss");
  a_mn_word_hold: assert property (mn_tx_valid_out && !mn_tx_ready_in
    |=> mn_tx_valid_out && $stable(mn_tx_data_out))
    else $error("memory net word dropped before accept");
  a_gn_word_hold: assert property (gn_tx_valid_out && !gn_tx_ready_in
    |=> gn_tx_valid_out && $stable(gn_tx_data_out))
    else $error("general net word dropped before accept");
  a_mn_direct_out: assert property (mn_take_w
    |=> mn_tx_valid_out && mn_tx_data_out == $past(avs_writedata_in))
    else $error("memory net word not sent at once");
  a_gn_direct_out: assert property (gn_take_w
    |=> gn_tx_valid_out && gn_tx_data_out == $past(avs_writedata_in))
    else $error("general net word not sent at once");
  a_gn_pop_cause: assert property (gn_rx_ready_out
    |-> gn_rx_valid_in && avs_read_in && idx_w == `MHG_A_GEN_RX)
    else $error("general net word popped without read");
  a_wd_irq_cause: assert property ($rose(wd_irq_out) && !$past(cache_miss_in)
    |-> $past(gn_rx_valid_in, 2))
    else $error("watchdog fired without waiting data");
endmodule // mhg_net_iface_asserts

bind mhg_net_iface mhg_net_iface_asserts i_mhg_net_iface_asserts
(
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out), .cache_miss_in(cache_miss_in),
  .mn_tx_valid_out(mn_tx_valid_out), .mn_tx_data_out(mn_tx_data_out),
  .mn_tx_ready_in(mn_tx_ready_in), .gn_tx_valid_out(gn_tx_valid_out),
  .gn_tx_data_out(gn_tx_data_out), .gn_tx_ready_in(gn_tx_ready_in),
  .gn_rx_valid_in(gn_rx_valid_in), .gn_rx_ready_out(gn_rx_ready_out),
  .ext_irq_out(ext_irq_out), .wd_irq_out(wd_irq_out)
);

// file: hw/mhg_consts.vh
// Constants for the mesh header generator and network interface
// Contract
// R1: Tile header turns low operand bits, a tile number, into absolute X/Y.
// R2: Tile header copies immediate top 12 bits into header top 12 bits.
// R3: Tile header inserts own tile coordinates as origin fields.
// R4: Position, masks, adjusts and Y shift are held in a config register.
// R5: X is masked, Y is shifted then masked, both plus adjust.
// R6: 32-bit memory space split evenly among edge ports.
// R7: Memory header derives final route, absolute X and Y from address.
// R8: Memory header puts own X/Y in origin fields as return address.
// R9: Memory header copies immediate bits 12..4 to header bits 28..20.
// R10: Four-side map: side is bit 30, index bits 29..25; else 0, 30..26.
// R11: Bit31 zero: X is 0 or max X, route west/east, Y index shifted.
// R12: Bit31 one: Y is 0 or max Y, route north/south, X index shifted.
// R13: Memory net output words go straight to router; software keeps sends atomic.
// R14: During a cache miss pipeline is frozen; interrupts implicitly masked.
// R15: Incoming interrupt messages are always removed; external interrupt bit set.
// R16: Controller keeps one interrupt per tile outstanding until acknowledged.
// R17: Interrupt message: length zero and user field 1111.
// R18: General net output behaves as memory net output, no commit buffer.
// R19: Watchdog counts cycles data waits unread; clears on read or none.
// R20: Watchdog reaching its limit raises interrupt; handler drains and virtualises.
// R21: User codes 0000,0001,0010,0100,0101 are read, DMA reads, write, escape.
// R22: Codes 0111 DMA write, 1000 read reply, 1101 relay, 1111 reserved.
// R23: Code 1110 store ack; sender picks partner or non-partner counter.
// R24: Header: route 31-29, length 28-24, user, origin Y/X, abs Y, abs X.
// R25: Final route codes 0 none, 2 west, 3 south, 4 east, 5 north.
// R26: Header removed on delivery to tile, kept when leaving chip edge.
`ifndef MHG_CONSTS_VH
`define MHG_CONSTS_VH
// Register word indices, byte address bits 5..2
`define MHG_A_POS      4'h0
`define MHG_A_VIRT     4'h1
`define MHG_A_EDGE     4'h2
`define MHG_A_IMM      4'h3
`define MHG_A_TILE_OP  4'h4
`define MHG_A_MEM_OP   4'h5
`define MHG_A_RESULT   4'h6
`define MHG_A_MEM_TX   4'h7
`define MHG_A_GEN_TX   4'h8
`define MHG_A_MEM_RX   4'h9
`define MHG_A_GEN_RX   4'ha
`define MHG_A_STATUS   4'hb
`define MHG_A_WD_LIM   4'hc
`define MHG_A_ST_CNT   4'hd
// Final route codes
`define MHG_FR_NONE    3'h0
`define MHG_FR_WEST    3'h2
`define MHG_FR_SOUTH   3'h3
`define MHG_FR_EAST    3'h4
`define MHG_FR_NORTH   3'h5
// User field codes
`define MHG_USR_LINE_RD  4'h0
`define MHG_USR_DMA_RN   4'h1
`define MHG_USR_DMA_RW   4'h2
`define MHG_USR_LINE_WR  4'h4
`define MHG_USR_ESCAPE   4'h5
`define MHG_USR_DMA_WR   4'h7
`define MHG_USR_RD_REPLY 4'h8
`define MHG_USR_RELAY    4'hd
`define MHG_USR_STORE_ACK 4'he
`define MHG_USR_IRQ      4'hf
// Status bits
`define MHG_ST_EXT_IRQ 0
`define MHG_ST_WD      1
`define MHG_ST_RECOV   2
// Reset values
`define MHG_WD_LIM_RST 16'hffff
`endif

// file: hw/mhg_net_iface.v
// Header generator, network ports and watchdog for one mesh tile
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "mhg_consts.vh"
module mhg_net_iface
(
  input  wire        ref_clk_in,
  input  wire        arst_n_in,
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        cache_miss_in,
  output reg         mn_tx_valid_out,
  output reg  [31:0] mn_tx_data_out,
  input  wire        mn_tx_ready_in,
  output reg         gn_tx_valid_out,
  output reg  [31:0] gn_tx_data_out,
  input  wire        gn_tx_ready_in,
  input  wire        mn_rx_valid_in,
  input  wire [31:0] mn_rx_data_in,
  output wire        mn_rx_ready_out,
  input  wire        gn_rx_valid_in,
  input  wire [31:0] gn_rx_data_in,
  output wire        gn_rx_ready_out,
  output wire        ext_irq_out,
  output wire        wd_irq_out
);

  // Receive states on the memory net input
  localparam [1:0] RX_HDR  = 2'h0;
  localparam [1:0] RX_DATA = 2'h1;
  localparam [1:0] RX_SKIP = 2'h2;

  // Software written configuration and header result
  reg  [31:0] pos_r;
  reg  [31:0] virt_r;
  reg  [31:0] edge_r;
  reg  [15:0] imm_r;
  reg  [31:0] result_r;

  // Sticky flags, watchdog limit and count
  reg  [2:0]  status_r;
  reg  [15:0] wd_lim_r;
  reg  [15:0] wd_cnt_r;

  // Store ack counts, partner port and the rest
  reg  [7:0]  st_part_r;
  reg  [7:0]  st_other_r;

  // Receive walker: state and payload words still owed
  reg  [1:0]  rx_st_r;
  reg  [4:0]  rx_left_r;

  // Bus answer phase and combinational helpers
  reg         ack_r;
  reg         go;
  reg  [31:0] rd_val;

  // Config fields
  wire [4:0]  tile_x_position = pos_r[4:0];
  wire [4:0]  tile_y_position = pos_r[9:5];
  wire [4:0]  virt_x_mask     = virt_r[4:0];
  wire [4:0]  virt_y_mask     = virt_r[9:5];
  wire [4:0]  virt_x_adjust   = virt_r[14:10];
  wire [4:0]  virt_y_adjust   = virt_r[19:15];
  wire [2:0]  virt_y_shift    = virt_r[22:20];
  wire        four_side_map_enable = edge_r[0];
  wire [4:0]  edge_x_max      = edge_r[5:1];
  wire [4:0]  edge_y_max      = edge_r[10:6];
  wire [2:0]  port_x_shift    = edge_r[13:11];
  wire [2:0]  port_y_shift    = edge_r[16:14];
  // Sender that counts as the partner port for store acks
  wire [9:0]  partner_src     = edge_r[26:17];

  // Word index; no byte lanes, whole words only
  wire [3:0]  widx  = avs_address_in[5:2];
  wire        req   = avs_read_in | avs_write_in;
  wire        wr_go = go & avs_write_in;
  wire        rd_go = go & avs_read_in;

  // Tile header: mask X, shift and mask Y, add adjusts
  // Tile number is the low five operand bits, enough for 32 wide
  wire [31:0] tile_op = avs_writedata_in;
  wire [4:0]  tn_y    = tile_op[4:0] >> virt_y_shift;
  wire [4:0]  th_x    = (tile_op[4:0] & virt_x_mask) + virt_x_adjust; // R1 R5
  wire [4:0]  th_y    = (tn_y & virt_y_mask) + virt_y_adjust;         // R1 R5
  wire [31:0] tile_hdr = {imm_r[15:4],                              // R2
                          tile_y_position, tile_x_position,          // R3
                          th_y, th_x};

  // Memory header: address selects edge port; even split of space
  wire [31:0] mem_op = avs_writedata_in;                            // R6
  wire        side   = mem_op[30] & four_side_map_enable;          // R10
  wire [4:0]  pidx   = four_side_map_enable ? mem_op[29:25]
                                            : mem_op[30:26];        // R10
  wire [4:0]  px_idx = pidx >> port_x_shift;
  wire [4:0]  py_idx = pidx >> port_y_shift;
  reg  [2:0]  mh_fr;
  reg  [4:0]  mh_x;
  reg  [4:0]  mh_y;

  // Edge choice by address top bit
  // Side set picks the near edge, west or north; clear the far one
  always @*
  begin
    if (!mem_op[31])
    begin
      mh_x  = side ? 5'h00 : edge_x_max;                           // R11
      mh_fr = side ? `MHG_FR_WEST : `MHG_FR_EAST;                  // R11 R25
      mh_y  = py_idx;                                              // R11
    end
    else
    begin
      mh_y  = side ? 5'h00 : edge_y_max;                           // R12
      mh_fr = side ? `MHG_FR_NORTH : `MHG_FR_SOUTH;                // R12 R25
      mh_x  = px_idx;                                              // R12
    end
  end

  // Route, then immediate 12..4 into 28..20, then return address
  wire [31:0] mem_hdr = {mh_fr, imm_r[12:4],                        // R7 R9 R24
                         tile_y_position, tile_x_position,          // R8
                         mh_y, mh_x};                               // R7

  // Incoming memory net header fields
  wire [4:0]  rx_len = mn_rx_data_in[28:24];
  wire [3:0]  rx_usr = mn_rx_data_in[23:20];
  wire [9:0]  rx_src = mn_rx_data_in[19:10];
  wire        rx_irq = (rx_len == 5'h00) && (rx_usr == `MHG_USR_IRQ); // R17
  wire        rx_sack = (rx_usr == `MHG_USR_STORE_ACK);               // R23
  // Reads, writes, escape, relay and user codes carry payload up
  wire        rx_pay  = ~(rx_irq | rx_sack);                          // R21 R22
  wire        hdr_take = (rx_st_r == RX_HDR) & mn_rx_valid_in;

  // Bus side decides whether a request can be taken this cycle
  always @*
  begin
    go = req & ~ack_r & ~cache_miss_in;                            // R14
    if (avs_write_in && widx == `MHG_A_MEM_TX)
      go = go & (~mn_tx_valid_out | mn_tx_ready_in);               // R13
    else if (avs_write_in && widx == `MHG_A_GEN_TX)
      go = go & (~gn_tx_valid_out | gn_tx_ready_in);               // R18
    else if (avs_read_in && widx == `MHG_A_MEM_RX)
      go = go & (rx_st_r == RX_DATA) & mn_rx_valid_in;
    else if (avs_read_in && widx == `MHG_A_GEN_RX)
      go = go & gn_rx_valid_in;
  end

  // Two-phase answer keeps read data registered at the release edge
  assign avs_waitrequest_out = req & ~ack_r;

  // Pops only on the take edge, so a stalled read never loses a word
  wire mrx_pop = rd_go & (widx == `MHG_A_MEM_RX);
  wire grx_pop = rd_go & (widx == `MHG_A_GEN_RX);

  // Header and skipped words drain without software; payload on read
  assign mn_rx_ready_out = (rx_st_r == RX_HDR) | (rx_st_r == RX_SKIP)
                           | mrx_pop;                              // R15 R26
  assign gn_rx_ready_out = grx_pop;

  // Read mux
  always @*
  begin
    // Unmapped and write only words read as zero
    rd_val = 32'h0000_0000;
    if (widx == `MHG_A_POS)
      rd_val = pos_r;
    else if (widx == `MHG_A_VIRT)
      rd_val = virt_r;
    else if (widx == `MHG_A_EDGE)
      rd_val = edge_r;
    else if (widx == `MHG_A_IMM)
      rd_val = {16'h0000, imm_r};
    else if (widx == `MHG_A_RESULT)
      rd_val = result_r;
    else if (widx == `MHG_A_MEM_RX)
      rd_val = mn_rx_data_in;
    else if (widx == `MHG_A_GEN_RX)
      rd_val = gn_rx_data_in;
    else if (widx == `MHG_A_STATUS)
      rd_val = {29'h0, status_r};
    else if (widx == `MHG_A_WD_LIM)
      rd_val = {wd_cnt_r, wd_lim_r};
    else if (widx == `MHG_A_ST_CNT)
      rd_val = {16'h0000, st_other_r, st_part_r};
  end

  // Bus handshake and readback
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ack_r            <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= go;
      // Readdata moves only on a taken read and stands until the next
      if (rd_go)
        avs_readdata_out <= rd_val;
    end
  end

  // Config registers and header results
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pos_r    <= 32'h0000_0000;
      virt_r   <= 32'h0000_0000;
      edge_r   <= 32'h0000_0000;
      imm_r    <= 16'h0000;
      result_r <= 32'h0000_0000;
      wd_lim_r <= `MHG_WD_LIM_RST;
    end
    else if (wr_go)
    begin
      if (widx == `MHG_A_POS)
        pos_r <= avs_writedata_in;                                 // R4
      else if (widx == `MHG_A_VIRT)
        virt_r <= avs_writedata_in;                                // R4
      else if (widx == `MHG_A_EDGE)
        edge_r <= avs_writedata_in;
      else if (widx == `MHG_A_IMM)
        imm_r <= avs_writedata_in[15:0];
      else if (widx == `MHG_A_TILE_OP)
        result_r <= tile_hdr;                                      // R1
      else if (widx == `MHG_A_MEM_OP)
        result_r <= mem_hdr;                                       // R7
      else if (widx == `MHG_A_WD_LIM)
        wd_lim_r <= avs_writedata_in[15:0];
    end
  end

  // Output words: one holding stage, no commit buffer or queue
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mn_tx_valid_out <= 1'b0;
      mn_tx_data_out  <= 32'h0000_0000;
      gn_tx_valid_out <= 1'b0;
      gn_tx_data_out  <= 32'h0000_0000;
    end
    else
    begin
      // A write may reload the slot on the edge the router takes it
      if (wr_go && widx == `MHG_A_MEM_TX)
      begin
        mn_tx_valid_out <= 1'b1;                                   // R13
        mn_tx_data_out  <= avs_writedata_in;
      end
      else if (mn_tx_ready_in)
        mn_tx_valid_out <= 1'b0;
      if (wr_go && widx == `MHG_A_GEN_TX)
      begin
        gn_tx_valid_out <= 1'b1;                                   // R18
        gn_tx_data_out  <= avs_writedata_in;
      end
      else if (gn_tx_ready_in)
        gn_tx_valid_out <= 1'b0;
    end
  end

  // Memory net receive: strip header, swallow interrupt and store ack
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rx_st_r   <= RX_HDR;
      rx_left_r <= 5'h00;
    end
    else
    begin
      case (rx_st_r)
        // Zero length headers, interrupts among them, need no walk
        RX_HDR:
          if (mn_rx_valid_in && rx_len != 5'h00)
          begin
            rx_left_r <= rx_len;
            rx_st_r   <= rx_pay ? RX_DATA : RX_SKIP;               // R26
          end
        RX_DATA:
          if (mrx_pop)
          begin
            rx_left_r <= rx_left_r - 5'h01;
            if (rx_left_r == 5'h01)
              rx_st_r <= RX_HDR;
          end
        // Store ack payload drains here with no software help
        RX_SKIP:
          if (mn_rx_valid_in)
          begin
            rx_left_r <= rx_left_r - 5'h01;
            if (rx_left_r == 5'h01)
              rx_st_r <= RX_HDR;
          end
        default:
          rx_st_r <= RX_HDR;
      endcase
    end
  end

  // Store ack counters; sender match picks the partner count
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_part_r  <= 8'h00;
      st_other_r <= 8'h00;
    end
    else if (hdr_take && rx_sack)
    begin
      if (rx_src == partner_src)
        st_part_r <= st_part_r + 8'h01;                            // R23
      else
        st_other_r <= st_other_r + 8'h01;                          // R23
    end
    else if (wr_go && widx == `MHG_A_ST_CNT)
    begin
      st_part_r  <= avs_writedata_in[7:0];
      st_other_r <= avs_writedata_in[15:8];
    end
  end

  // Watchdog: counts unread waiting cycles, holds at the limit
  // A zero limit disables the watchdog
  wire wd_hit = (wd_cnt_r == wd_lim_r) && (wd_lim_r != 16'h0000);
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wd_cnt_r <= 16'h0000;
    else if (!gn_rx_valid_in || grx_pop)
      wd_cnt_r <= 16'h0000;                                        // R19
    // Holding at the limit keeps the flag up instead of wrapping
    else if (!wd_hit)
      wd_cnt_r <= wd_cnt_r + 16'h0001;                             // R19
  end

  // Status: sticky interrupt and watchdog flags, write one to clear, a set beats the clear
  wire [2:0] st_clr = (wr_go && widx == `MHG_A_STATUS) ? avs_writedata_in[2:0] : 3'h0;
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      status_r <= 3'h0;
    else
    begin
      // The far controller sends no second interrupt until handled
      if (hdr_take && rx_irq)
        status_r[`MHG_ST_EXT_IRQ] <= 1'b1;                         // R15 R17
      else if (st_clr[`MHG_ST_EXT_IRQ])
        status_r[`MHG_ST_EXT_IRQ] <= 1'b0;
      if (wd_hit)
        status_r[`MHG_ST_WD] <= 1'b1;                              // R20
      else if (st_clr[`MHG_ST_WD])
        status_r[`MHG_ST_WD] <= 1'b0;
      // Recovery flag is software owned, plain read/write
      if (wr_go && widx == `MHG_A_STATUS)
        status_r[`MHG_ST_RECOV] <= avs_writedata_in[`MHG_ST_RECOV]; // R20
    end
  end

  // Interrupt lines masked while the pipeline is frozen on a miss
  // The flags cannot be cleared under a miss but can still be set; only the lines are gated
  assign ext_irq_out = status_r[`MHG_ST_EXT_IRQ] & ~cache_miss_in; // R14
  assign wd_irq_out  = status_r[`MHG_ST_WD] & ~cache_miss_in;      // R20

endmodule // mhg_net_iface
